/* sdm_pkg.sv */
`default_nettype none

package sdm_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int N_WORDS = 2;
    localparam int N_SNMI = 9;
    localparam int N_UNMI = 1;
    localparam int N_RST = 16;
    localparam int VEC_W = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_MAILBOX_CONTROL = 5'h06;
    localparam logic [ADDR_W-1:0] OFS_INCOMING_WORD_ZERO = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_INCOMING_WORD_ONE = 5'h0A;
    localparam logic [ADDR_W-1:0] OFS_OUTGOING_WORD_ZERO = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_OUTGOING_WORD_ONE = 5'h0E;
    localparam logic [ADDR_W-1:0] OFS_USER_NMI_VECTOR = 5'h1A;
    localparam logic [ADDR_W-1:0] OFS_SYSTEM_NMI_VECTOR = 5'h1C;
    localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE_VECTOR = 5'h1E;

    // mailbox_control bit positions
    localparam int CB_IN_WORD0_NEW_DATA = 0;
    localparam int CB_IN_WORD1_NEW_DATA = 1;
    localparam int CB_OUT_WORD0_READY = 2;
    localparam int CB_OUT_WORD1_READY = 3;
    localparam int CB_WIDE_MESSAGE_SELECT = 4;
    localparam int CB_IN_WORD0_AUTOCLEAR_DISABLE = 6;
    localparam int CB_IN_WORD1_AUTOCLEAR_DISABLE = 7;

    localparam logic [N_WORDS-1:0] OUT_READY_INIT = 2'h3;
    localparam logic [N_WORDS-1:0] ALL_WORDS = 2'h3;

    // system nmi source positions, highest priority first
    localparam int SN_LOW_SIDE_MONITOR = 0;
    localparam int SN_HIGH_SIDE_MONITOR = 1;
    localparam int SN_LOW_DELAY = 2;
    localparam int SN_HIGH_DELAY = 3;
    localparam int SN_VACANT_MEMORY_ACCESS = 4;
    localparam int SN_MAILBOX_IN = 5;
    localparam int SN_MAILBOX_OUT = 6;
    localparam int SN_LOW_REGULATOR_FAULT = 7;
    localparam int SN_HIGH_REGULATOR_FAULT = 8;

    localparam int UN_PIN_NMI = 0;

    // reset cause positions, highest priority first
    localparam int RC_BROWNOUT = 0;
    localparam int RC_RESET_PIN = 1;
    localparam int RC_SOFTWARE_BROWNOUT = 2;
    localparam int RC_PORT_WAKEUP = 3;
    localparam int RC_SECURITY_VIOLATION = 4;
    localparam int RC_LOW_SUPPLY_SUPERVISOR = 5;
    localparam int RC_HIGH_SUPPLY_SUPERVISOR = 6;
    localparam int RC_LOW_MONITOR_OVERVOLTAGE = 7;
    localparam int RC_HIGH_MONITOR_OVERVOLTAGE = 8;
    localparam int RC_SOFTWARE_POWERON = 9;
    localparam int RC_WATCHDOG_TIMEOUT = 10;
    localparam int RC_WATCHDOG_PASSWORD = 11;
    localparam int RC_FLASH_PASSWORD_VIOLATION = 12;
    localparam int RC_PLL_UNLOCK = 13;
    localparam int RC_PERIPHERAL_AREA_FETCH = 14;
    localparam int RC_POWER_MGMT_PASSWORD = 15;

    localparam logic [N_RST-1:0] RST_PEND_INIT = 16'h0001;

    localparam logic [VEC_W-1:0] VEC_NONE = 16'h0000;
    localparam int VEC_STEP = 2;

    // lowest set position wins; code is (position + 1) * step
    function automatic logic [VEC_W-1:0] sdm_vec_code(input logic [N_RST-1:0] pend);
        logic [VEC_W-1:0] code;
        code = VEC_NONE;
        for (int i = N_RST - 1; i >= 0; i--) begin
            if (pend[i]) begin
                code = VEC_W'((i + 1) * VEC_STEP);
            end
        end
        return code;
    endfunction : sdm_vec_code

endpackage : sdm_pkg

`default_nettype wire

/* sdm_mailbox.sv */
// The address-and-strobe port and the register offsets are this design's own decisions.
`default_nettype none

module sdm_mailbox (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [sdm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sdm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [1:0] reg_wbe,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sdm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [sdm_pkg::N_SNMI-1:0] sys_nmi_event,
    input wire logic pin_nmi_flag,
    input wire logic [sdm_pkg::N_RST-1:0] reset_cause_event,
    output logic system_nmi_req,
    output logic user_nmi_req,
    input wire logic jtag_clk,
    input wire logic jtag_srst,
    input wire logic host_in_wr,
    input wire logic host_in_sel,
    input wire logic [sdm_pkg::DATA_W-1:0] host_in_data,
    input wire logic host_out_rd,
    input wire logic host_out_sel,
    output logic [sdm_pkg::DATA_W-1:0] host_outgoing_word_zero,
    output logic [sdm_pkg::DATA_W-1:0] host_outgoing_word_one,
    output logic [sdm_pkg::N_WORDS-1:0] host_out_valid
);

    typedef struct packed {
        logic [sdm_pkg::DATA_W-1:0] rd_data;
        logic [sdm_pkg::N_WORDS-1:0][sdm_pkg::DATA_W-1:0] in_word;
        logic [sdm_pkg::N_WORDS-1:0][sdm_pkg::DATA_W-1:0] out_word;
        logic [sdm_pkg::N_WORDS-1:0] in_new_data;
        logic [sdm_pkg::N_WORDS-1:0] out_ready;
        logic [sdm_pkg::N_WORDS-1:0] autoclear_disable;
        logic wide_message_select;
        logic [sdm_pkg::N_SNMI-1:0] snmi_pend;
        logic [sdm_pkg::N_UNMI-1:0] unmi_pend;
        logic [sdm_pkg::N_RST-1:0] rst_pend;
        logic [sdm_pkg::N_WORDS-1:0] in_tgl_s1;
        logic [sdm_pkg::N_WORDS-1:0] in_tgl_s2;
        logic [sdm_pkg::N_WORDS-1:0] in_tgl_seen;
        logic [sdm_pkg::N_WORDS-1:0] rd_tgl_s1;
        logic [sdm_pkg::N_WORDS-1:0] rd_tgl_s2;
        logic [sdm_pkg::N_WORDS-1:0] rd_tgl_seen;
        logic [sdm_pkg::N_WORDS-1:0] out_tgl;
        logic snmi_req;
        logic unmi_req;
    } sdm_core_t;

    typedef struct packed {
        logic [sdm_pkg::N_WORDS-1:0][sdm_pkg::DATA_W-1:0] in_data;
        logic [sdm_pkg::N_WORDS-1:0][sdm_pkg::DATA_W-1:0] out_data;
        logic [sdm_pkg::N_WORDS-1:0] out_valid;
        logic [sdm_pkg::N_WORDS-1:0] in_tgl;
        logic [sdm_pkg::N_WORDS-1:0] rd_tgl;
        logic [sdm_pkg::N_WORDS-1:0] out_tgl_s1;
        logic [sdm_pkg::N_WORDS-1:0] out_tgl_s2;
        logic [sdm_pkg::N_WORDS-1:0] out_tgl_seen;
    } sdm_link_t;

    sdm_core_t core;
    sdm_core_t next_core;
    sdm_link_t link;
    sdm_link_t next_link;

    logic [sdm_pkg::N_WORDS-1:0] arrive;
    logic [sdm_pkg::N_WORDS-1:0] host_read;
    logic [sdm_pkg::N_WORDS-1:0] rd_in;
    logic [sdm_pkg::N_WORDS-1:0] wr_out;
    logic [sdm_pkg::N_WORDS-1:0] autoclear;
    logic wr_ctrl_lo;
    logic mailbox_in_event;
    logic mailbox_out_event;
    logic [sdm_pkg::N_SNMI-1:0] snmi_src;
    logic [sdm_pkg::DATA_W-1:0] ctrl_view;

    always_comb begin
        next_core = core;

        // two-stage toggle synchronisers from the link side
        next_core.in_tgl_s1 = link.in_tgl;
        next_core.in_tgl_s2 = core.in_tgl_s1;
        next_core.in_tgl_seen = core.in_tgl_s2;
        next_core.rd_tgl_s1 = link.rd_tgl;
        next_core.rd_tgl_s2 = core.rd_tgl_s1;
        next_core.rd_tgl_seen = core.rd_tgl_s2;
        arrive = core.in_tgl_s2 ^ core.in_tgl_seen;
        host_read = core.rd_tgl_s2 ^ core.rd_tgl_seen;

        rd_in[0] = reg_rd && (reg_addr == sdm_pkg::OFS_INCOMING_WORD_ZERO);
        rd_in[1] = reg_rd && (reg_addr == sdm_pkg::OFS_INCOMING_WORD_ONE);
        wr_out[0] = reg_wr && (reg_addr == sdm_pkg::OFS_OUTGOING_WORD_ZERO);
        wr_out[1] = reg_wr && (reg_addr == sdm_pkg::OFS_OUTGOING_WORD_ONE);
        wr_ctrl_lo = reg_wr && reg_wbe[0] && (reg_addr == sdm_pkg::OFS_MAILBOX_CONTROL);

        // in wide mode a read of word one also releases word zero
        autoclear[0] = !core.autoclear_disable[0]
            && (rd_in[0] || (core.wide_message_select && rd_in[1]));
        autoclear[1] = !core.autoclear_disable[1] && rd_in[1];

        if (wr_ctrl_lo) begin
            next_core.wide_message_select = reg_wdata[sdm_pkg::CB_WIDE_MESSAGE_SELECT];
            next_core.autoclear_disable[0] = reg_wdata[sdm_pkg::CB_IN_WORD0_AUTOCLEAR_DISABLE];
            next_core.autoclear_disable[1] = reg_wdata[sdm_pkg::CB_IN_WORD1_AUTOCLEAR_DISABLE];
            next_core.in_new_data[0] = reg_wdata[sdm_pkg::CB_IN_WORD0_NEW_DATA];
            next_core.in_new_data[1] = reg_wdata[sdm_pkg::CB_IN_WORD1_NEW_DATA];
        end
        // an arrival in the clearing cycle must not be lost, so set goes last
        next_core.in_new_data = (next_core.in_new_data & ~autoclear) | arrive;

        for (int i = 0; i < sdm_pkg::N_WORDS; i++) begin
            if (arrive[i]) begin
                next_core.in_word[i] = link.in_data[i];
            end
            if (wr_out[i]) begin
                if (reg_wbe[0]) begin
                    next_core.out_word[i][7:0] = reg_wdata[7:0];
                end
                if (reg_wbe[1]) begin
                    next_core.out_word[i][15:8] = reg_wdata[15:8];
                    next_core.out_ready[i] = 1'b0;
                end
                // every write refreshes the host copy, even a low byte alone
                next_core.out_tgl[i] = ~core.out_tgl[i];
            end
        end
        next_core.out_ready = next_core.out_ready | host_read;

        mailbox_in_event = core.wide_message_select
            ? ((arrive != '0) && (next_core.in_new_data == sdm_pkg::ALL_WORDS))
            : arrive[0];
        mailbox_out_event = core.wide_message_select
            ? ((host_read != '0) && (next_core.out_ready == sdm_pkg::ALL_WORDS))
            : host_read[0];

        snmi_src = sys_nmi_event;
        snmi_src[sdm_pkg::SN_MAILBOX_IN] = sys_nmi_event[sdm_pkg::SN_MAILBOX_IN]
            || mailbox_in_event;
        snmi_src[sdm_pkg::SN_MAILBOX_OUT] = sys_nmi_event[sdm_pkg::SN_MAILBOX_OUT]
            || mailbox_out_event;

        // a vector write clears all pending bits of that vector only; a source firing in that cycle survives
        if (reg_wr && (reg_addr == sdm_pkg::OFS_SYSTEM_NMI_VECTOR)) begin
            next_core.snmi_pend = '0;
        end
        next_core.snmi_pend = next_core.snmi_pend | snmi_src;
        if (reg_wr && (reg_addr == sdm_pkg::OFS_USER_NMI_VECTOR)) begin
            next_core.unmi_pend = '0;
        end
        next_core.unmi_pend[sdm_pkg::UN_PIN_NMI] = next_core.unmi_pend[sdm_pkg::UN_PIN_NMI]
            | pin_nmi_flag;
        if (reg_wr && (reg_addr == sdm_pkg::OFS_RESET_CAUSE_VECTOR)) begin
            next_core.rst_pend = '0;
        end
        next_core.rst_pend = next_core.rst_pend | reset_cause_event;

        next_core.snmi_req = |next_core.snmi_pend;
        next_core.unmi_req = |next_core.unmi_pend;

        ctrl_view = '0;
        ctrl_view[sdm_pkg::CB_IN_WORD0_NEW_DATA] = core.in_new_data[0];
        ctrl_view[sdm_pkg::CB_IN_WORD1_NEW_DATA] = core.in_new_data[1];
        ctrl_view[sdm_pkg::CB_OUT_WORD0_READY] = core.out_ready[0];
        ctrl_view[sdm_pkg::CB_OUT_WORD1_READY] = core.out_ready[1];
        ctrl_view[sdm_pkg::CB_WIDE_MESSAGE_SELECT] = core.wide_message_select;
        ctrl_view[sdm_pkg::CB_IN_WORD0_AUTOCLEAR_DISABLE] = core.autoclear_disable[0];
        ctrl_view[sdm_pkg::CB_IN_WORD1_AUTOCLEAR_DISABLE] = core.autoclear_disable[1];

        // read data stands one cycle only; unmapped offsets read zero
        next_core.rd_data = '0;
        if (reg_rd) begin
            case (reg_addr)
                sdm_pkg::OFS_MAILBOX_CONTROL: begin
                    next_core.rd_data = ctrl_view;
                end
                sdm_pkg::OFS_INCOMING_WORD_ZERO: begin
                    next_core.rd_data = core.in_word[0];
                end
                sdm_pkg::OFS_INCOMING_WORD_ONE: begin
                    next_core.rd_data = core.in_word[1];
                end
                sdm_pkg::OFS_OUTGOING_WORD_ZERO: begin
                    next_core.rd_data = core.out_word[0];
                end
                sdm_pkg::OFS_OUTGOING_WORD_ONE: begin
                    next_core.rd_data = core.out_word[1];
                end
                sdm_pkg::OFS_USER_NMI_VECTOR: begin
                    next_core.rd_data = sdm_pkg::sdm_vec_code(
                        sdm_pkg::N_RST'(core.unmi_pend));
                end
                sdm_pkg::OFS_SYSTEM_NMI_VECTOR: begin
                    // unused high positions stay zero, so later codes remain reserved
                    next_core.rd_data = sdm_pkg::sdm_vec_code(
                        sdm_pkg::N_RST'(core.snmi_pend));
                end
                sdm_pkg::OFS_RESET_CAUSE_VECTOR: begin
                    next_core.rd_data = sdm_pkg::sdm_vec_code(core.rst_pend);
                end
                default: begin
                    next_core.rd_data = '0;
                end
            endcase
        end

        if (srst) begin
            next_core = '0;
            next_core.out_ready = sdm_pkg::OUT_READY_INIT;
            // a fresh start reports itself as a brownout
            next_core.rst_pend = sdm_pkg::RST_PEND_INIT;
        end
    end

    always_ff @(posedge core_clk) begin
        core <= next_core;
    end

    always_comb begin
        next_link = link;

        next_link.out_tgl_s1 = core.out_tgl;
        next_link.out_tgl_s2 = link.out_tgl_s1;
        next_link.out_tgl_seen = link.out_tgl_s2;

        if (host_in_wr) begin
            next_link.in_data[host_in_sel] = host_in_data;
            next_link.in_tgl[host_in_sel] = ~link.in_tgl[host_in_sel];
        end

        // only a read of a loaded word counts as taking the message
        if (host_out_rd && link.out_valid[host_out_sel]) begin
            next_link.out_valid[host_out_sel] = 1'b0;
            next_link.rd_tgl[host_out_sel] = ~link.rd_tgl[host_out_sel];
        end

        // core word is stable here: it was written in the same cycle its toggle moved
        for (int i = 0; i < sdm_pkg::N_WORDS; i++) begin
            if (link.out_tgl_s2[i] != link.out_tgl_seen[i]) begin
                next_link.out_data[i] = core.out_word[i];
                next_link.out_valid[i] = 1'b1;
            end
        end

        if (jtag_srst) begin
            next_link = '0;
        end
    end

    always_ff @(posedge jtag_clk) begin
        link <= next_link;
    end

    assign reg_rdata = core.rd_data;
    assign system_nmi_req = core.snmi_req;
    assign user_nmi_req = core.unmi_req;
    assign host_outgoing_word_zero = link.out_data[0];
    assign host_outgoing_word_one = link.out_data[1];
    assign host_out_valid = link.out_valid;

endmodule : sdm_mailbox

`default_nettype wire

/* sdm_mailbox_assertions.sv */
`default_nettype none
module sdm_mailbox_checker (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [sdm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [1:0] reg_wbe,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [sdm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [sdm_pkg::N_SNMI-1:0] sys_nmi_event,
    input wire logic pin_nmi_flag,
    input wire logic system_nmi_req,
    input wire logic user_nmi_req,
    input wire logic jtag_clk,
    input wire logic jtag_srst,
    input wire logic host_out_rd,
    input wire logic host_out_sel,
    input wire logic [sdm_pkg::DATA_W-1:0] host_outgoing_word_zero,
    input wire logic [sdm_pkg::N_WORDS-1:0] host_out_valid
);
    logic wr_sn;
    logic wr_un;
    assign wr_sn = reg_wr && reg_addr == sdm_pkg::OFS_SYSTEM_NMI_VECTOR;
    assign wr_un = reg_wr && reg_addr == sdm_pkg::OFS_USER_NMI_VECTOR;
    property p_sn_clear;
        @(posedge core_clk) disable iff (srst) wr_sn && sys_nmi_event == '0
            ##1 sys_nmi_event == '0 ##1 reg_rd && sys_nmi_event == '0
            && reg_addr == sdm_pkg::OFS_SYSTEM_NMI_VECTOR |=> reg_rdata == '0;
    endproperty
    a_sn_clear: assert property (p_sn_clear)
        else $error("system vector kept after clear");
    property p_sn_req;
        @(posedge core_clk) disable iff (srst)
            (|sys_nmi_event) ##1 !wr_sn |-> ##[0:1] system_nmi_req;
    endproperty
    a_sn_req: assert property (p_sn_req)
        else $error("system request missing after event");
    property p_un_req;
        @(posedge core_clk) disable iff (srst) pin_nmi_flag ##1 !wr_un |-> ##[0:1] user_nmi_req;
    endproperty
    a_un_req: assert property (p_un_req)
        else $error("user request missing after pin event");
    property p_vec_fmt;
        @(posedge core_clk) disable iff (srst) reg_rd && (reg_addr ==
            sdm_pkg::OFS_SYSTEM_NMI_VECTOR || reg_addr == sdm_pkg::OFS_RESET_CAUSE_VECTOR)
            |=> reg_rdata[15:6] == '0 && !reg_rdata[0];
    endproperty
    a_vec_fmt: assert property (p_vec_fmt)
        else $error("vector code out of form");
    property p_un_code;
        @(posedge core_clk) disable iff (srst) reg_rd && reg_addr ==
            sdm_pkg::OFS_USER_NMI_VECTOR |=> reg_rdata inside {16'h0000, 16'h0002};
    endproperty
    a_un_code: assert property (p_un_code)
        else $error("user vector code out of range");
    property p_out_clr;
        @(posedge core_clk) disable iff (srst) reg_wr && reg_wbe[1]
            && reg_addr == sdm_pkg::OFS_OUTGOING_WORD_ZERO ##2 reg_rd
            && reg_addr == sdm_pkg::OFS_MAILBOX_CONTROL
            |=> !reg_rdata[sdm_pkg::CB_OUT_WORD0_READY];
    endproperty
    a_out_clr: assert property (p_out_clr)
        else $error("outgoing ready still set after write");
    property p_valid_fall;
        @(posedge jtag_clk) disable iff (jtag_srst)
            $fell(host_out_valid[0]) |-> $past(host_out_rd) && !$past(host_out_sel);
    endproperty
    a_valid_fall: assert property (p_valid_fall)
        else $error("outgoing word dropped without host read");
    property p_word_chg;
        @(posedge jtag_clk) disable iff (jtag_srst)
            $changed(host_outgoing_word_zero) |-> host_out_valid[0];
    endproperty
    a_word_chg: assert property (p_word_chg)
        else $error("host copy changed without valid");
endmodule : sdm_mailbox_checker

bind sdm_mailbox sdm_mailbox_checker sdm_mailbox_checker_i (.core_clk, .srst, .reg_addr,
    .reg_wbe, .reg_wr, .reg_rd, .reg_rdata, .sys_nmi_event, .pin_nmi_flag, .system_nmi_req,
    .user_nmi_req, .jtag_clk, .jtag_srst, .host_out_rd, .host_out_sel,
    .host_outgoing_word_zero, .host_out_valid);
`default_nettype wire

/* sdm_host_model.sv */
`default_nettype none
module sdm_host_model (
    input wire logic jtag_clk,
    output logic host_in_wr,
    output logic host_in_sel,
    output logic [sdm_pkg::DATA_W-1:0] host_in_data,
    output logic host_out_rd,
    output logic host_out_sel,
    input wire logic [sdm_pkg::DATA_W-1:0] host_outgoing_word_zero,
    input wire logic [sdm_pkg::DATA_W-1:0] host_outgoing_word_one,
    input wire logic [sdm_pkg::N_WORDS-1:0] host_out_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        host_in_wr = 1'b0;
        host_in_sel = 1'b0;
        host_in_data = 16'h0000;
        host_out_rd = 1'b0;
        host_out_sel = 1'b0;
    end
    // released data shows the inverse, so a stale capture cannot pass
    task automatic put(input logic sel, input logic [15:0] d);
        @(posedge jtag_clk);
        host_in_wr <= 1'b1;
        host_in_sel <= sel;
        host_in_data <= d;
        @(posedge jtag_clk);
        host_in_wr <= 1'b0;
        host_in_data <= ~d;
    endtask : put
    task automatic take(input logic sel, output logic [15:0] d);
        int n;
        n = 0;
        do begin
            @(posedge jtag_clk);
            #1;
            n++;
        end while (host_out_valid[sel] !== 1'b1 && n < 200);
        host_out_rd <= 1'b1;
        host_out_sel <= sel;
        @(posedge jtag_clk);
        d = sel ? host_outgoing_word_one : host_outgoing_word_zero;
        host_out_rd <= 1'b0;
    endtask : take
endmodule : sdm_host_model
`default_nettype wire

/* sdm_mailbox_bench.sv */
`default_nettype none
module sdm_mailbox_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [4:0] CT = sdm_pkg::OFS_MAILBOX_CONTROL;
    localparam logic [4:0] SN = sdm_pkg::OFS_SYSTEM_NMI_VECTOR;
    localparam logic [4:0] UN = sdm_pkg::OFS_USER_NMI_VECTOR;
    localparam logic [4:0] RV = sdm_pkg::OFS_RESET_CAUSE_VECTOR;
    logic core_clk = 1'b0, jtag_clk = 1'b0, srst = 1'b1, jtag_srst = 1'b1;
    logic [4:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0, reg_rdata, host_in_data, w0, w1, reset_cause_event = '0;
    logic [1:0] reg_wbe = '0, host_out_valid;
    logic reg_wr = 1'b0, reg_rd = 1'b0, pin_nmi_flag = 1'b0;
    logic [8:0] sys_nmi_event = '0;
    logic system_nmi_req, user_nmi_req, host_in_wr, host_in_sel, host_out_rd, host_out_sel;
    int err_count = 0;
    int num_checks = 0;
    always #2.5 core_clk = ~core_clk;
    initial begin
        #3.7;
        forever #15 jtag_clk = ~jtag_clk;
    end
    sdm_mailbox sdm_mailbox_i (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wbe, .reg_wr,
        .reg_rd, .reg_rdata, .sys_nmi_event, .pin_nmi_flag, .reset_cause_event,
        .system_nmi_req, .user_nmi_req, .jtag_clk, .jtag_srst, .host_in_wr, .host_in_sel,
        .host_in_data, .host_out_rd, .host_out_sel, .host_outgoing_word_zero(w0),
        .host_outgoing_word_one(w1), .host_out_valid);
    sdm_host_model sdm_host_model_i (.jtag_clk, .host_in_wr, .host_in_sel, .host_in_data,
        .host_out_rd, .host_out_sel, .host_outgoing_word_zero(w0),
        .host_outgoing_word_one(w1), .host_out_valid);
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] v, input logic [1:0] be);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        reg_wbe <= be;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rdc
    // the flags cross from the link clock, so they are polled with a bound
    task automatic poll(input int b, input logic v);
        logic [15:0] c;
        int n;
        n = 0;
        do begin
            rd(CT, c);
            n++;
        end while (c[b] !== v && n < 40);
        chk(16'(c[b]), 16'(v));
    endtask : poll
    function automatic logic [15:0] lowest(input logic [15:0] p);
        lowest = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            if (p[i]) lowest = 16'((i + 1) * 2);
        end
    endfunction : lowest
    task automatic sweep(input logic [4:0] a, input int n);
        logic [15:0] m;
        for (int i = 0; i < n; i++) begin
            wr(a, 16'($urandom), 2'b11);
            m = (16'($urandom) & (16'hFFFF << i) | (16'h0001 << i)) & 16'((1 << n) - 1);
            @(posedge core_clk);
            sys_nmi_event <= (a == SN) ? m[8:0] : 9'h000;
            pin_nmi_flag <= (a == UN) && m[0];
            reset_cause_event <= (a == RV) ? m : 16'h0000;
            @(posedge core_clk);
            sys_nmi_event <= '0;
            pin_nmi_flag <= 1'b0;
            reset_cause_event <= '0;
            rdc(a, lowest(m));
            rdc(a, lowest(m));
        end
        wr(a, 16'($urandom), 2'b11);
        rdc(a, 16'h0000);
    endtask : sweep
    initial begin
        #300000;
        err_count++;
        close_out();
    end
    initial begin
        logic [15:0] v, m;
        void'($urandom(32'h351490d0));
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        jtag_srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        rdc(RV, 16'h0002);
        rdc(CT, 16'h000C);
        rdc(UN, 16'h0000);
        rdc(5'h10, 16'h0000);
        sweep(RV, 16);
        sweep(SN, 9);
        sweep(UN, 1);
        v = 16'($urandom);
        sdm_host_model_i.put(1'b0, v);
        poll(sdm_pkg::CB_IN_WORD0_NEW_DATA, 1'b1);
        rdc(SN, 16'h000C);
        rdc(sdm_pkg::OFS_INCOMING_WORD_ZERO, v);
        poll(sdm_pkg::CB_IN_WORD0_NEW_DATA, 1'b0);
        wr(CT, 16'h0040, 2'b11);
        sdm_host_model_i.put(1'b0, ~v);
        poll(sdm_pkg::CB_IN_WORD0_NEW_DATA, 1'b1);
        rdc(sdm_pkg::OFS_INCOMING_WORD_ZERO, ~v);
        poll(sdm_pkg::CB_IN_WORD0_NEW_DATA, 1'b1);
        wr(CT, 16'h0040, 2'b11);
        poll(sdm_pkg::CB_IN_WORD0_NEW_DATA, 1'b0);
        // wide pairing: a read of word one also retires word zero
        wr(CT, 16'h0010, 2'b11);
        sdm_host_model_i.put(1'b0, v);
        sdm_host_model_i.put(1'b1, ~v);
        poll(sdm_pkg::CB_IN_WORD1_NEW_DATA, 1'b1);
        rdc(sdm_pkg::OFS_INCOMING_WORD_ONE, ~v);
        poll(sdm_pkg::CB_IN_WORD0_NEW_DATA, 1'b0);
        poll(sdm_pkg::CB_IN_WORD1_NEW_DATA, 1'b0);
        wr(CT, 16'h0000, 2'b11);
        v = 16'($urandom);
        wr(sdm_pkg::OFS_OUTGOING_WORD_ZERO, v, 2'b01);
        poll(sdm_pkg::CB_OUT_WORD0_READY, 1'b1);
        sdm_host_model_i.take(1'b0, m);
        chk(m, {8'h00, v[7:0]});
        // the host read is still crossing; its late set would undo the next clear
        repeat (8) @(posedge core_clk);
        wr(sdm_pkg::OFS_OUTGOING_WORD_ZERO, v, 2'b11);
        poll(sdm_pkg::CB_OUT_WORD0_READY, 1'b0);
        sdm_host_model_i.take(1'b0, m);
        chk(m, v);
        poll(sdm_pkg::CB_OUT_WORD0_READY, 1'b1);
        // wide outgoing: word one, mailbox-out event only once both words are ready
        wr(CT, 16'h0010, 2'b11);
        wr(SN, 16'($urandom), 2'b11);
        rdc(SN, 16'h0000);
        chk(16'(system_nmi_req), 16'h0000);
        wr(sdm_pkg::OFS_OUTGOING_WORD_ONE, ~v, 2'b11);
        poll(sdm_pkg::CB_OUT_WORD1_READY, 1'b0);
        sdm_host_model_i.take(1'b1, m);
        chk(m, ~v);
        poll(sdm_pkg::CB_OUT_WORD1_READY, 1'b1);
        rdc(SN, 16'h000E);
        chk(16'(system_nmi_req), 16'h0001);
        close_out();
    end
endmodule : sdm_mailbox_bench
`default_nettype wire
